/* File: core/i2cx_map.svh */
// register offsets, field positions, reset values and timing counts of the i2c controller
// assumes a 25 MHz system clock and byte-wide registers on a plain strobe port
`ifndef I2CX_MAP_SVH
`define I2CX_MAP_SVH
// register byte offsets
`define I2CX_A_CTRL2 8'h00
`define I2CX_A_STAT2 8'h04
`define I2CX_A_IEN 8'h08
`define I2CX_A_FEN 8'h0c
`define I2CX_A_MODE3 8'h10
`define I2CX_A_TXD 8'h14
`define I2CX_A_RXD 8'h18
`define I2CX_A_GEN 8'h1c
`define I2CX_A_GST 8'h20
// bus_control_two fields
`define I2CX_C2_SP 1
`define I2CX_C2_BUSY 7
// bus_status_two fields
`define I2CX_S2_AL 0
`define I2CX_S2_TMO 1
`define I2CX_S2_STOP 3
`define I2CX_S2_NACK 4
`define I2CX_S2_RXF 5
`define I2CX_S2_TRANSMIT_END_FLAG 6
`define I2CX_S2_TXE 7
// irq_enable_reg fields
`define I2CX_IE_TRANSMIT_END_FLAG 0
`define I2CX_IE_RXF 1
`define I2CX_IE_TXE 2
`define I2CX_IE_ERR 3
// function_enable_reg fields
`define I2CX_FE_AL 0
`define I2CX_FE_TMO 1
// mode_reg_three fields
`define I2CX_M3_WAIT 0
`define I2CX_M3_ACK_VALUE_BIT 1
`define I2CX_M3_ACK_WRITE_ENABLE 2
// group bits
`define I2CX_G_TRANSMIT_END_FLAG 0
`define I2CX_G_ERR 1
// reset values
`define I2CX_RST_FEN 2'h0
`define I2CX_RST_IEN 4'h0
`define I2CX_RST_GEN 2'h0
// own slave address
`define I2CX_OWN_ADDR 7'h50
// timing
`define I2CX_CLK_NS 40
`define I2CX_STP_NS 5000
`define I2CX_STP_CYC ((`I2CX_STP_NS + `I2CX_CLK_NS - 1) / `I2CX_CLK_NS)
`define I2CX_TMO_NS 50000
`define I2CX_TMO_CYC (`I2CX_TMO_NS / `I2CX_CLK_NS)
`endif

/* File: core/i2cx_pkg.sv */
// types shared by the i2c controller modules
// assumes nothing beyond a synthesizable systemverilog tool flow
package i2cx_pkg;
  typedef logic [7:0] i2cx_byte_t;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_TX_LOAD, ST_TXB, ST_TX_ACK,
    ST_RXB, ST_RX_ACK} i2cx_state_t;
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } i2cx_sync_t;
  typedef struct packed {
    i2cx_state_t st;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic rw;
    logic sda_drv;
    logic sp;
    logic busy;
    logic fl_al;
    logic fl_to;
    logic fl_stp;
    logic fl_nack;
    logic fl_transmit_end_flag;
    logic rxf;
    logic txe;
    logic [3:0] ien;
    logic [1:0] fen;
    logic wt;
    logic ack_value_bit;
    logic ack_write_enable;
    logic [7:0] txd;
    logic [7:0] rxd;
    logic [1:0] gen;
    logic [1:0] stph;
    logic [11:0] stcnt;
    logic [11:0] tocnt;
    logic [7:0] rdata;
    logic scl_oe_n;
    logic sda_oe_n;
    logic irq_txe;
    logic irq_rxf;
    logic irq_grp;
  } i2cx_regs_t;
endpackage : i2cx_pkg

/* File: core/i2cx_sync.sv */
// three-flop synchroniser with level and edge outputs for one bus pin
// assumes the pin is asynchronous to clk; edges come from the second and third flops
module i2cx_sync
  import i2cx_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic pin,
  output logic lvl,
  output logic rise,
  output logic fall
);
  i2cx_sync_t q, d;

  // shift chain
  always_comb
  begin
    d = q;
    d.s1 = pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (rst)
      q <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1};
    else if (ce)
      q <= d;
  end

  assign lvl = q.s2;
  assign rise = q.s2 & ~q.s3;
  assign fall = ~q.s2 & q.s3;
endmodule : i2cx_sync

/* File: core/i2cx_ctrl.sv */
// i2c controller: slave transmit/receive engine, stop generator, register port
// assumes SCL/SDA pins resolved outside from the enables; register master on SYS_CLK
// Function
// (RULE1) writing one to stop_request_bit makes the controller drive a stop condition
// (RULE2) software polls the stop flag until it reads one after a stop request
// (RULE3) software writes zero to nack_seen_flag to finish a transfer
// (RULE4) software writes zero to the stop flag to finish a transfer
// (RULE5) transmit-end handler disables group source, clears flag, then clears enable
// (RULE6) error events reach only the shared group interrupt, identified by status bit
// (RULE7) handler checks group error status before looking at controller flags
// (RULE8) arbitration lost flag set means software does error processing
// (RULE9) nack flag set means error or normal transfer-end processing
// (RULE10) timeout flag set means software does error processing
// (RULE11) stop flag set during error handling means the transfer is finished
// (RULE12) arbitration-lost and timeout detection each switch off in function_enable_reg
// (RULE13) every byte takes nine clocks: eight data bits and one acknowledge
// (RULE14) no wait is inserted between the eighth data bit and acknowledge
// (RULE15) a received not-acknowledge halts the transfer
// (RULE16) the controller answers to its seven-bit slave address
// (RULE17) the slave sends a block then receives a block of equal length; the code only sends or only receives, as the address R/W bit selects
// (RULE18) transmit-empty and receive-full interrupts request and deliver each byte
// (RULE19) wait bit set holds SCL low between the ninth and next first clock
// (RULE20) ack_value_bit takes writes only while ack_write_enable is one
// (RULE21) stop detection sets a flag that stays until software writes zero
module i2cx_ctrl
  import i2cx_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic CE,
  input wire i2cx_pkg::i2cx_byte_t ADDR,
  input wire i2cx_pkg::i2cx_byte_t WDATA,
  input wire logic WR,
  input wire logic RD,
  output i2cx_pkg::i2cx_byte_t RDATA,
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE_N,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_N,
  output logic TX_EMPTY_IRQ,
  output logic RX_FULL_IRQ,
  output logic GROUP_IRQ
);
  `include "i2cx_map.svh"
  i2cx_regs_t q, d;
  logic scl_lvl, scl_rise, scl_fall, sda_lvl, sda_rise, sda_fall;
  logic hold, err_src, transmit_end_flag_src;
  logic [7:0] stat2;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  i2cx_sync u_scl (.clk(SYS_CLK), .rst(RESET), .ce(CE), .pin(SCL_I), .lvl(scl_lvl),
    .rise(scl_rise), .fall(scl_fall));
  i2cx_sync u_sda (.clk(SYS_CLK), .rst(RESET), .ce(CE), .pin(SDA_I), .lvl(sda_lvl),
    .rise(sda_rise), .fall(sda_fall));

  //////////////////////////////////////////////////////////////////////////////
  // status views shared by the read mux and the group logic
  always_comb
  begin
    stat2 = 8'h00;
    stat2[`I2CX_S2_AL] = q.fl_al;
    stat2[`I2CX_S2_TMO] = q.fl_to;
    stat2[`I2CX_S2_STOP] = q.fl_stp;
    stat2[`I2CX_S2_NACK] = q.fl_nack;
    stat2[`I2CX_S2_RXF] = q.rxf;
    stat2[`I2CX_S2_TRANSMIT_END_FLAG] = q.fl_transmit_end_flag;
    stat2[`I2CX_S2_TXE] = q.txe;
    err_src = q.ien[`I2CX_IE_ERR] & (q.fl_al | q.fl_to | q.fl_nack | q.fl_stp); // [RULE6]
    transmit_end_flag_src = q.ien[`I2CX_IE_TRANSMIT_END_FLAG] & q.fl_transmit_end_flag;
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state: software access first, hardware events after so sets win
  always_comb
  begin
    d = q;
    hold = 1'b0;
    // register writes
    if (WR)
    begin
      unique case (ADDR)
        `I2CX_A_CTRL2: if (WDATA[`I2CX_C2_SP]) d.sp = 1'b1; // [RULE1]
        `I2CX_A_STAT2:
        begin
          d.fl_al = q.fl_al & WDATA[`I2CX_S2_AL];
          d.fl_to = q.fl_to & WDATA[`I2CX_S2_TMO];
          d.fl_stp = q.fl_stp & WDATA[`I2CX_S2_STOP]; // [RULE21]
          d.fl_nack = q.fl_nack & WDATA[`I2CX_S2_NACK];
          d.fl_transmit_end_flag = q.fl_transmit_end_flag & WDATA[`I2CX_S2_TRANSMIT_END_FLAG];
        end
        `I2CX_A_IEN: d.ien = WDATA[3:0];
        `I2CX_A_FEN: d.fen = WDATA[1:0]; // [RULE12]
        `I2CX_A_MODE3:
        begin
          d.wt = WDATA[`I2CX_M3_WAIT];
          d.ack_write_enable = WDATA[`I2CX_M3_ACK_WRITE_ENABLE];
          if (q.ack_write_enable) d.ack_value_bit = WDATA[`I2CX_M3_ACK_VALUE_BIT]; // [RULE20]
        end
        `I2CX_A_TXD:
        begin
          d.txd = WDATA;
          d.txe = 1'b0;
        end
        `I2CX_A_GEN: d.gen = WDATA[1:0];
        default: ;
      endcase
    end
    // register reads, data valid in the next cycle only
    d.rdata = 8'h00;
    if (RD)
    begin
      unique case (ADDR)
        `I2CX_A_CTRL2: d.rdata = {q.busy, 5'h00, q.sp, 1'b0};
        `I2CX_A_STAT2: d.rdata = stat2;
        `I2CX_A_IEN: d.rdata = {4'h0, q.ien};
        `I2CX_A_FEN: d.rdata = {6'h00, q.fen};
        `I2CX_A_MODE3: d.rdata = {5'h00, q.ack_write_enable, q.ack_value_bit, q.wt};
        `I2CX_A_TXD: d.rdata = q.txd;
        `I2CX_A_RXD:
        begin
          d.rdata = q.rxd;
          d.rxf = 1'b0;
        end
        `I2CX_A_GEN: d.rdata = {6'h00, q.gen};
        `I2CX_A_GST: d.rdata = {6'h00, err_src, transmit_end_flag_src}; // [RULE6]
        default: d.rdata = 8'h00;
      endcase
    end
    // bus conditions and the byte engine
    if (sda_rise && scl_lvl)
    begin
      d.st = ST_IDLE;
      d.fl_stp = 1'b1; // [RULE21]
      d.busy = 1'b0;
      d.sda_drv = 1'b0;
    end
    else if (sda_fall && scl_lvl)
    begin
      d.st = ST_ADDR;
      d.bitc = 4'h0;
      d.busy = 1'b1;
      d.sda_drv = 1'b0;
    end
    else
    begin
      unique case (q.st)
        ST_IDLE: ;
        ST_ADDR:
        begin
          if (scl_rise)
          begin
            d.sh = {q.sh[6:0], sda_lvl};
            d.bitc = q.bitc + 4'h1;
          end
          if (scl_fall && q.bitc == 4'h8)
          begin
            if (q.sh[7:1] == `I2CX_OWN_ADDR) // [RULE16]
            begin
              d.rw = q.sh[0];
              d.sda_drv = 1'b1;
              d.st = ST_ADDR_ACK;
            end
            else
              d.st = ST_IDLE;
          end
        end
        ST_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            d.sda_drv = 1'b0;
            d.bitc = 4'h0;
            d.st = q.rw ? ST_TX_LOAD : ST_RXB; // [RULE17]
          end
        end
        ST_TX_LOAD:
        begin
          if (!scl_lvl && !(q.wt && q.txe)) // [RULE19]
          begin
            d.sh = q.txd;
            d.txe = 1'b1; // [RULE18]
            d.sda_drv = ~q.txd[7];
            d.bitc = 4'h0;
            d.st = ST_TXB;
          end
        end
        ST_TXB:
        begin
          if (scl_rise)
          begin
            d.bitc = q.bitc + 4'h1;
            if (q.fen[`I2CX_FE_AL] && !q.sda_drv && !sda_lvl) // [RULE12]
            begin
              d.fl_al = 1'b1;
              d.st = ST_IDLE;
            end
          end
          if (scl_fall)
          begin
            if (q.bitc == 4'h8) // [RULE13] [RULE14]
            begin
              d.sda_drv = 1'b0;
              d.st = ST_TX_ACK;
            end
            else
            begin
              d.sh = {q.sh[6:0], 1'b0};
              d.sda_drv = ~q.sh[6];
            end
          end
        end
        ST_TX_ACK:
        begin
          if (scl_rise)
          begin
            if (sda_lvl) // [RULE15]
            begin
              d.fl_nack = 1'b1;
              d.fl_transmit_end_flag = 1'b1;
              d.st = ST_IDLE;
            end
            else
            begin
              d.fl_transmit_end_flag = q.txe;
              d.st = ST_TX_LOAD;
            end
          end
        end
        ST_RXB:
        begin
          if (scl_rise)
          begin
            d.sh = {q.sh[6:0], sda_lvl};
            d.bitc = q.bitc + 4'h1;
          end
          if (scl_fall && q.bitc == 4'h8) // [RULE13] [RULE14]
          begin
            d.rxd = q.sh;
            d.rxf = 1'b1; // [RULE18]
            d.sda_drv = ~q.ack_value_bit;
            d.st = ST_RX_ACK;
          end
        end
        ST_RX_ACK:
        begin
          if (scl_fall)
          begin
            d.sda_drv = 1'b0;
            d.bitc = 4'h0;
            d.st = ST_RXB;
          end
        end
      endcase
    end
    // bus timeout while a transfer is open and SCL stands still
    if (q.fen[`I2CX_FE_TMO] && q.st != ST_IDLE && !scl_rise && !scl_fall) // [RULE12]
      d.tocnt = q.tocnt + 12'h001;
    else
      d.tocnt = 12'h000;
    if (q.tocnt == 12'(`I2CX_TMO_CYC - 1))
    begin
      d.fl_to = 1'b1;
      d.st = ST_IDLE;
      d.sda_drv = 1'b0;
      d.tocnt = 12'h000;
    end
    // stop generator: SDA low with SCL low, release SCL, then release SDA
    unique case (q.stph)
      2'h0:
      begin
        d.stcnt = 12'h000;
        if (q.sp) d.stph = 2'h1; // [RULE1]
      end
      2'h1, 2'h2:
      begin
        d.stcnt = q.stcnt + 12'h001;
        if (q.stcnt == 12'(`I2CX_STP_CYC - 1))
        begin
          d.stcnt = 12'h000;
          d.stph = q.stph + 2'h1;
        end
      end
      2'h3:
      begin
        d.stph = 2'h0;
        d.sp = 1'b0;
      end
    endcase
    // pin and interrupt outputs taken from the next state
    hold = (d.st == ST_TX_LOAD && d.wt && d.txe) || (d.st == ST_RXB && d.bitc == 4'h0 &&
      d.wt && d.rxf) || d.stph == 2'h1; // [RULE19]
    d.scl_oe_n = ~hold;
    d.sda_oe_n = ~(d.sda_drv || d.stph == 2'h1 || d.stph == 2'h2);
    d.irq_txe = d.txe & d.busy & d.rw & d.ien[`I2CX_IE_TXE]; // [RULE18]
    d.irq_rxf = d.rxf & d.ien[`I2CX_IE_RXF];
    d.irq_grp = (d.gen[`I2CX_G_ERR] & d.ien[`I2CX_IE_ERR] & (d.fl_al | d.fl_to | d.fl_nack |
      d.fl_stp)) | (d.gen[`I2CX_G_TRANSMIT_END_FLAG] & d.ien[`I2CX_IE_TRANSMIT_END_FLAG] & d.fl_transmit_end_flag); // [RULE6]
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register, frozen while CE is low
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      q <= '0;
      q.st <= ST_IDLE;
      q.txe <= 1'b1;
      q.ien <= `I2CX_RST_IEN;
      q.fen <= `I2CX_RST_FEN;
      q.gen <= `I2CX_RST_GEN;
      q.scl_oe_n <= 1'b1;
      q.sda_oe_n <= 1'b1;
    end
    else if (CE)
      q <= d;
  end

  // outputs; the pin data lines are only ever pulled low
  assign RDATA = q.rdata;
  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;
  assign SCL_OE_N = q.scl_oe_n;
  assign SDA_OE_N = q.sda_oe_n;
  assign TX_EMPTY_IRQ = q.irq_txe;
  assign RX_FULL_IRQ = q.irq_rxf;
  assign GROUP_IRQ = q.irq_grp;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET || !CE);

  stop_request_a: assert property (WR && ADDR == `I2CX_A_CTRL2 && WDATA[`I2CX_C2_SP] // [RULE1]
    |=> q.sp ##1 q.stph == 2'h1 ##1 !SDA_OE_N && !SCL_OE_N)
    else $error("stop request did not start the stop sequence");
  group_route_a: assert property (err_src && q.gen[`I2CX_G_ERR] |-> GROUP_IRQ) // [RULE6]
    else $error("error event did not reach the group interrupt");
  al_disabled_a: assert property (!q.fen[`I2CX_FE_AL] && !q.fl_al |=> !q.fl_al) // [RULE12]
    else $error("arbitration lost set while disabled");
  nine_clocks_a: assert property (q.bitc <= 4'h8) // [RULE13]
    else $error("bit counter passed nine clocks");
  nack_halt_a: assert property (q.st == ST_TX_ACK && scl_rise && sda_lvl && !sda_rise // [RULE15]
    |=> q.st == ST_IDLE && q.fl_nack && SDA_OE_N)
    else $error("not-acknowledge did not halt the transfer");
  addr_miss_a: assert property (q.st == ST_ADDR && scl_fall && q.bitc == 4'h8 && // [RULE16]
    q.sh[7:1] != `I2CX_OWN_ADDR && !(sda_rise && scl_lvl) |=> q.st == ST_IDLE)
    else $error("foreign address was answered");
  rx_full_a: assert property ($rose(q.rxf) && q.ien[`I2CX_IE_RXF] && !RD |-> RX_FULL_IRQ) // [RULE18]
    else $error("receive-full interrupt missing");
  wait_hold_a: assert property (q.st == ST_RXB && q.bitc == 4'h0 && q.wt && q.rxf // [RULE19]
    && !WR && !RD |-> !SCL_OE_N)
    else $error("wait did not hold SCL low");
  ack_protect_a: assert property (WR && ADDR == `I2CX_A_MODE3 && !q.ack_write_enable // [RULE20]
    |=> q.ack_value_bit == $past(q.ack_value_bit))
    else $error("ack value changed while protected");
  stop_sticky_a: assert property (q.fl_stp && !(WR && ADDR == `I2CX_A_STAT2) // [RULE21]
    |=> q.fl_stp)
    else $error("stop flag dropped without a clear");
endmodule : i2cx_ctrl

/* File: sim/i2cx_master_model.sv */
// i2c bus master model: start, stop and nine-clock byte transfers on open-drain lines
// assumes the bench resolves SCL and SDA with pull-ups from every party's drive
module i2cx_master_model
(
  input wire logic scl,
  input wire logic sda,
  output logic scl_m,
  output logic sda_m
);
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////////////////////////
  // both lines released while the bus is idle
  initial
  begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  // start: SDA falls while SCL is high
  task automatic start_c();
    sda_m = 1'b1;
    scl_m = 1'b1;
    #160;
    sda_m = 1'b0;
    #160;
    scl_m = 1'b0;
    #80;
  endtask : start_c
  // stop: SDA rises while SCL is high
  task automatic stop_c();
    sda_m = 1'b0;
    #80;
    scl_m = 1'b1;
    #160;
    sda_m = 1'b1;
    #160;
  endtask : stop_c
  // one bit: data changes only with SCL low, a held-low SCL is waited out
  task automatic bit_c(input logic b, output logic r);
    int n;
    n = 0;
    sda_m = b;
    #80;
    scl_m = 1'b1;
    while (scl !== 1'b1 && n < 2000)
    begin
      #10;
      n++;
    end
    #80;
    r = sda;
    #80;
    scl_m = 1'b0;
    #80;
  endtask : bit_c
  // eight data bits msb first, then the acknowledge clock
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
    output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_c(d[i], q[i]);
    bit_c(ack_in, ack);
  endtask : xfer
endmodule : i2cx_master_model

/* File: sim/tb_i2cx_ctrl.sv */
// self-checking bench for the i2c controller: register port tasks and master-driven frames
// assumes the master model on the pins and pull-ups on both wires
module tb_i2cx_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  import i2cx_pkg::*;
  `include "i2cx_map.svh"
  logic sys_clk, reset, wr, rd, scl_o, scl_oe_n, sda_o, sda_oe_n, tx_irq, rx_irq, grp_irq;
  logic scl_m, sda_m, ack;
  wire logic scl_w, sda_w;
  i2cx_byte_t addr, wdata, rdata, q;
  int errors, total_checks;
  ////////////////////////////////////////////////////////////////////////////////
  // wired-and of the open-drain lines, pulled up when nobody drives
  assign scl_w = scl_m & (scl_oe_n | scl_o);
  assign sda_w = sda_m & (sda_oe_n | sda_o);
  i2cx_ctrl dut (.SYS_CLK(sys_clk), .RESET(reset), .CE(1'b1), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .SCL_I(scl_w), .SCL_O(scl_o), .SCL_OE_N(scl_oe_n),
    .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE_N(sda_oe_n), .TX_EMPTY_IRQ(tx_irq),
    .RX_FULL_IRQ(rx_irq), .GROUP_IRQ(grp_irq));
  i2cx_master_model m (.scl(scl_w), .sda(sda_w), .scl_m(scl_m), .sda_m(sda_m));
  ////////////////////////////////////////////////////////////////////////////////
  // 25 MHz system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // verdict and end of run
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out
  // one-cycle write strobe
  task automatic wr_reg(input i2cx_byte_t a, input i2cx_byte_t d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : wr_reg
  // one-cycle read strobe, data taken in the following cycle
  task automatic rd_reg(input i2cx_byte_t a, output i2cx_byte_t d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(negedge sys_clk);
    d = rdata;
  endtask : rd_reg
  // byte compare
  task automatic chk(input i2cx_byte_t got, input i2cx_byte_t exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  // single-bit compare
  task automatic chk_b(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk_b
  // register read and compare
  task automatic chk_reg(input i2cx_byte_t a, input i2cx_byte_t exp, input string what);
    i2cx_byte_t d;
    rd_reg(a, d);
    chk(d, exp, what);
  endtask : chk_reg
  // bounded poll of the stop flag
  task automatic wait_stop();
    i2cx_byte_t d;
    int n;
    n = 0;
    d = 8'h00;
    while (d[`I2CX_S2_STOP] !== 1'b1 && n < 400)
    begin
      rd_reg(`I2CX_A_STAT2, d);
      n++;
    end
    if (d[`I2CX_S2_STOP] !== 1'b1)
    begin
      errors++;
      $display("wrong value at %0t: stop flag never set", $time);
      close_out();
    end
  endtask : wait_stop
  // hang guard
  initial
  begin
    #3000000;
    errors++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    reset = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    chk_reg(`I2CX_A_FEN, 8'h00, "fen reset");
    chk_reg(`I2CX_A_IEN, 8'h00, "ien reset");
    chk_reg(`I2CX_A_GEN, 8'h00, "gen reset");
    chk_reg(`I2CX_A_STAT2, 8'h80, "status reset");
    chk_reg(8'h30, 8'h00, "unmapped");
    wr_reg(`I2CX_A_MODE3, 8'h02);
    chk_reg(`I2CX_A_MODE3, 8'h00, "ack bit locked");
    wr_reg(`I2CX_A_IEN, 8'h06);
    // master writes two bytes, the second refused by the ack value bit
    m.start_c();
    m.xfer({`I2CX_OWN_ADDR, 1'b0}, 1'b1, q, ack);
    chk_b(ack, 1'b0, "write address ack");
    m.xfer(8'h3c, 1'b1, q, ack);
    chk_b(ack, 1'b0, "data ack");
    chk_b(rx_irq, 1'b1, "rx full irq");
    chk_reg(`I2CX_A_RXD, 8'h3c, "rx byte");
    repeat (2) @(posedge sys_clk);
    chk_b(rx_irq, 1'b0, "rx irq after read");
    wr_reg(`I2CX_A_MODE3, 8'h07);
    wr_reg(`I2CX_A_MODE3, 8'h03);
    chk_reg(`I2CX_A_MODE3, 8'h03, "ack bit written");
    m.xfer(8'hc3, 1'b1, q, ack);
    chk_b(ack, 1'b1, "ack value one");
    repeat (4) @(posedge sys_clk);
    chk_b(scl_oe_n, 1'b0, "wait holds scl");
    chk_reg(`I2CX_A_RXD, 8'hc3, "second rx byte");
    m.stop_c();
    wait_stop();
    chk_reg(`I2CX_A_STAT2, 8'h88, "stop flag");
    wr_reg(`I2CX_A_STAT2, 8'h00);
    chk_reg(`I2CX_A_STAT2, 8'h80, "stop cleared");
    wr_reg(`I2CX_A_MODE3, 8'h04);
    wr_reg(`I2CX_A_MODE3, 8'h00);
    // foreign address is not acknowledged
    m.start_c();
    m.xfer({`I2CX_OWN_ADDR + 7'h01, 1'b1}, 1'b1, q, ack);
    chk_b(ack, 1'b1, "foreign address");
    m.stop_c();
    wait_stop();
    wr_reg(`I2CX_A_STAT2, 8'h00);
    // slave transmit ended by a master not-acknowledge
    wr_reg(`I2CX_A_TXD, 8'ha5);
    m.start_c();
    m.xfer({`I2CX_OWN_ADDR, 1'b1}, 1'b1, q, ack);
    chk_b(ack, 1'b0, "read address ack");
    m.xfer(8'hff, 1'b1, q, ack);
    chk(q, 8'ha5, "tx byte");
    chk_b(tx_irq, 1'b1, "tx empty irq");
    m.stop_c();
    wait_stop();
    chk_reg(`I2CX_A_STAT2, 8'hd8, "nack transmit_end_flag stop");
    // transmit-end source through the group, then the handler's shutdown order
    wr_reg(`I2CX_A_IEN, 8'h01);
    wr_reg(`I2CX_A_GEN, 8'h01);
    repeat (2) @(posedge sys_clk);
    chk_b(grp_irq, 1'b1, "transmit_end_flag group irq");
    wr_reg(`I2CX_A_GEN, 8'h00);
    wr_reg(`I2CX_A_STAT2, 8'hbf);
    wr_reg(`I2CX_A_IEN, 8'h00);
    chk_reg(`I2CX_A_STAT2, 8'h98, "transmit_end_flag cleared");
    // error source reaches only the group interrupt
    wr_reg(`I2CX_A_IEN, 8'h08);
    wr_reg(`I2CX_A_GEN, 8'h02);
    rd_reg(`I2CX_A_GST, q);
    chk(q & 8'h02, 8'h02, "group error status");
    chk_reg(`I2CX_A_STAT2, 8'h98, "error flags");
    chk_b(grp_irq, 1'b1, "group irq");
    wr_reg(`I2CX_A_STAT2, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk_b(grp_irq, 1'b0, "group irq cleared");
    chk_reg(`I2CX_A_STAT2, 8'h80, "flags cleared");
    // stop request drives both lines, then a stop follows
    wr_reg(`I2CX_A_CTRL2, 8'h02);
    repeat (4) @(posedge sys_clk);
    chk_b(sda_oe_n | scl_oe_n, 1'b0, "stop drive");
    wait_stop();
    chk_reg(`I2CX_A_CTRL2, 8'h00, "request self clear");
    wr_reg(`I2CX_A_STAT2, 8'h00);
    chk_reg(`I2CX_A_STAT2, 8'h80, "idle status");
    close_out();
  end
endmodule : tb_i2cx_ctrl
